// File: lcce_cfg.svh
// opcode patterns, instruction lengths and machine-cycle counts
// assumes a core clock at 100 MHz and four clocks per machine cycle
`ifndef LCCE_CFG_SVH
`define LCCE_CFG_SVH

`define LCCE_MC_CLKS       4'h4
`define LCCE_CNT_W         4

`define LCCE_OP_AND_A_RN   5'h0B
`define LCCE_OP_AND_A_DIR  8'h55
`define LCCE_OP_AND_A_IND  7'h2B
`define LCCE_OP_AND_A_IMM  8'h54
`define LCCE_OP_AND_D_A    8'h52
`define LCCE_OP_AND_D_IMM  8'h53
`define LCCE_OP_AND_C_BIT  8'h82
`define LCCE_OP_AND_C_NBIT 8'hB0
`define LCCE_OP_CMP_A_DIR  8'hB5
`define LCCE_OP_CMP_A_IMM  8'hB4
`define LCCE_OP_CMP_RN     5'h17
`define LCCE_OP_CMP_IND    7'h5B
`define LCCE_OP_CLR_A      8'hE4
`define LCCE_OP_CLR_C      8'hC3
`define LCCE_OP_CLR_BIT    8'hC2
`define LCCE_OP_CPL_A      8'hF4
`define LCCE_OP_CPL_C      8'hB3
`define LCCE_OP_CPL_BIT    8'hB2

`define LCCE_CYC_ONE       3'h1
`define LCCE_CYC_TWO       3'h2
`define LCCE_CYC_THREE     3'h3
`define LCCE_CYC_CMP       3'h4

`define LCCE_LEN_ONE       2'h1
`define LCCE_LEN_TWO       2'h2
`define LCCE_LEN_THREE     2'h3

`define LCCE_BITRAM_BASE   8'h20
`define LCCE_SFR_BASE      8'h80
`define LCCE_PC_RST        16'h0000
`endif

// File: lcce_pkg.sv
// types shared by the decoder and the execution unit
// no assumptions beyond the cfg header
package lcce_pkg;
	typedef enum logic [3:0] {
		OPC_NONE,
		OPC_AND_BYTE,
		OPC_AND_BIT,
		OPC_CMP,
		OPC_CLR_A,
		OPC_CPL_A,
		OPC_CLR_C,
		OPC_CPL_C,
		OPC_CLR_BIT,
		OPC_CPL_BIT
	} lcce_opc_t;

	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_REG,
		SRC_IND,
		SRC_DIR,
		SRC_BIT
	} lcce_src_t;
endpackage : lcce_pkg

// File: lcce_decode.sv
// opcode decoder for the and / compare-branch / clear / complement group
// combinational; the opcode comes from a register in the execution unit
`include "lcce_cfg.svh"
module lcce_decode
	import lcce_pkg::*;
(
	// opcode in
	input  wire logic [7:0] i_opcode,
	// decoded fields
	output lcce_opc_t       o_opc,
	output lcce_src_t       o_src,
	output logic            o_dst_dir,
	output logic            o_use_imm,
	output logic            o_inv,
	output logic [2:0]      o_cycles,
	output logic [1:0]      o_len
);
	always_comb begin
		o_opc     = OPC_NONE;
		o_src     = SRC_NONE;
		o_dst_dir = 1'b0;
		o_use_imm = 1'b0;
		o_inv     = 1'b0;
		o_cycles  = `LCCE_CYC_ONE;
		o_len     = `LCCE_LEN_ONE;
		if (i_opcode[7:3] == `LCCE_OP_AND_A_RN) begin
			o_opc = OPC_AND_BYTE;
			o_src = SRC_REG;
		end else if (i_opcode[7:1] == `LCCE_OP_AND_A_IND) begin
			o_opc = OPC_AND_BYTE;
			o_src = SRC_IND;
		end else if (i_opcode[7:3] == `LCCE_OP_CMP_RN) begin
			o_opc    = OPC_CMP;
			o_src    = SRC_REG;
			o_cycles = `LCCE_CYC_CMP;
			o_len    = `LCCE_LEN_THREE;
		end else if (i_opcode[7:1] == `LCCE_OP_CMP_IND) begin
			o_opc    = OPC_CMP;
			o_src    = SRC_IND;
			o_cycles = `LCCE_CYC_CMP;
			o_len    = `LCCE_LEN_THREE;
		end else begin
			unique case (i_opcode)
				`LCCE_OP_AND_A_DIR: begin
					o_opc = OPC_AND_BYTE;
					o_src = SRC_DIR;
					o_cycles = `LCCE_CYC_TWO;
					o_len = `LCCE_LEN_TWO;
				end
				`LCCE_OP_AND_A_IMM: begin
					o_opc = OPC_AND_BYTE;
					o_use_imm = 1'b1;
					o_cycles = `LCCE_CYC_TWO;
					o_len = `LCCE_LEN_TWO;
				end
				`LCCE_OP_AND_D_A: begin
					o_opc = OPC_AND_BYTE;
					o_src = SRC_DIR;
					o_dst_dir = 1'b1;
					o_cycles = `LCCE_CYC_TWO;
					o_len = `LCCE_LEN_TWO;
				end
				`LCCE_OP_AND_D_IMM: begin
					o_opc = OPC_AND_BYTE;
					o_src = SRC_DIR;
					o_dst_dir = 1'b1;
					o_use_imm = 1'b1;
					o_cycles = `LCCE_CYC_THREE;
					o_len = `LCCE_LEN_THREE;
				end
				`LCCE_OP_AND_C_BIT, `LCCE_OP_AND_C_NBIT: begin
					o_opc = OPC_AND_BIT;
					o_src = SRC_BIT;
					o_inv = (i_opcode == `LCCE_OP_AND_C_NBIT);
					o_cycles = `LCCE_CYC_TWO;
					o_len = `LCCE_LEN_TWO;
				end
				`LCCE_OP_CMP_A_DIR: begin
					o_opc = OPC_CMP;
					o_src = SRC_DIR;
					o_cycles = `LCCE_CYC_CMP;
					o_len = `LCCE_LEN_THREE;
				end
				`LCCE_OP_CMP_A_IMM: begin
					o_opc = OPC_CMP;
					o_use_imm = 1'b1;
					o_cycles = `LCCE_CYC_CMP;
					o_len = `LCCE_LEN_THREE;
				end
				`LCCE_OP_CLR_A: o_opc = OPC_CLR_A;
				`LCCE_OP_CPL_A: o_opc = OPC_CPL_A;
				`LCCE_OP_CLR_C: o_opc = OPC_CLR_C;
				`LCCE_OP_CPL_C: o_opc = OPC_CPL_C;
				`LCCE_OP_CLR_BIT, `LCCE_OP_CPL_BIT: begin
					o_opc = (i_opcode == `LCCE_OP_CLR_BIT) ? OPC_CLR_BIT : OPC_CPL_BIT;
					o_src = SRC_BIT;
					o_cycles = `LCCE_CYC_TWO;
					o_len = `LCCE_LEN_TWO;
				end
				default: o_opc = OPC_NONE;
			endcase
		end
	end
endmodule : lcce_decode

// File: lcce_exec.sv
// execution unit for byte/bit and, compare-and-branch-if-unequal,
// and clear/complement of accumulator, carry or an addressable bit
// assumes: core supplies accumulator, carry, pc and bank on the same clock;
// internal data memory answers a read one clock after o_rd_en
//
// Operation
// - byte and writes the bitwise and of both operands, flags untouched
// - accumulator dest takes reg, direct, indirect, immediate; direct dest takes acc, immediate
// - byte and with a direct port destination reads the output latch, not the pins
// - bit and clears carry when source bit is zero, else keeps it
// - inverted variant uses complement of bit, addressed bit left alone
// - bit and source uses direct bit addressing only
// - compare branches only when operands differ, operands unmodified
// - pc advances by three, then adds signed offset if taken
// - compare sets carry when first operand below second, else clears it
// - accumulator compares against direct byte or immediate
// - indirect location or working register compares against immediate
// - clear accumulator zeroes all eight bits, flags untouched
// - bit clear zeroes carry or any direct bit only
// - complement accumulator inverts every bit, flags untouched
// - bit complement inverts carry or any direct bit only
// - bit complement on a pin reads the output latch
`include "lcce_cfg.svh"
module lcce_exec
	import lcce_pkg::*;
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	// instruction in
	input  wire logic        i_start,
	input  wire logic [7:0]  i_opcode,
	input  wire logic [7:0]  i_byte2,
	input  wire logic [7:0]  i_byte3,
	output logic             o_ready,
	// core state
	input  wire logic [7:0]  i_acc,
	input  wire logic        i_cy,
	input  wire logic [15:0] i_pc,
	input  wire logic [1:0]  i_bank,
	// data memory read
	output logic             o_rd_en,
	output logic [7:0]       o_rd_addr,
	output logic             o_rd_ind,
	output logic             o_rd_latch,
	input  wire logic [7:0]  i_rd_data,
	// data memory write
	output logic             o_wr_en,
	output logic [7:0]       o_wr_addr,
	output logic [7:0]       o_wr_data,
	// core state updates
	output logic             o_acc_we,
	output logic [7:0]       o_acc_data,
	output logic             o_cy_we,
	output logic             o_cy_data,
	output logic             o_pc_we,
	output logic [15:0]      o_pc_data,
	// completion
	output logic             o_done,
	output logic             o_bad_op
);
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_PTR  = 5'h02,
		S_RD   = 5'h04,
		S_RDW  = 5'h08,
		S_EXEC = 5'h10
	} lcce_state_t;

	lcce_state_t             state_q;
	lcce_opc_t               dec_opc;
	lcce_src_t               dec_src;
	logic                    dec_dst_dir;
	logic                    dec_use_imm;
	logic                    dec_inv;
	logic [2:0]              dec_cycles;
	logic [1:0]              dec_len;
	logic [7:0]              opcode_q;
	logic [7:0]              b2_q;
	logic [7:0]              b3_q;
	logic [15:0]             pc_q;
	logic [1:0]              bank_q;
	logic [7:0]              opnd_q;
	logic [`LCCE_CNT_W-1:0]  cnt_q;
	logic [`LCCE_CNT_W-1:0]  last_cnt;
	logic [7:0]              bit_byte;
	logic [2:0]              bit_pos;
	logic                    commit;

	lcce_decode u_decode (
		.i_opcode  (opcode_q),
		.o_opc     (dec_opc),
		.o_src     (dec_src),
		.o_dst_dir (dec_dst_dir),
		.o_use_imm (dec_use_imm),
		.o_inv     (dec_inv),
		.o_cycles  (dec_cycles),
		.o_len     (dec_len)
	);

	assign o_ready = (state_q == S_IDLE);

	// bit address: low half maps into the bit-addressable ram, high half onto sfr bytes
	assign bit_pos  = b2_q[2:0];
	assign bit_byte = b2_q[7] ? {b2_q[7:3], 3'b000} : (`LCCE_BITRAM_BASE | {4'h0, b2_q[6:3]});

	assign last_cnt = ({1'b0, dec_cycles} * `LCCE_MC_CLKS) - `LCCE_CNT_W'(1);
	assign commit   = (state_q == S_EXEC) && (cnt_q >= last_cnt);

	////////////////////////////////////////////////////////////////////////
	// instruction capture
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			opcode_q <= 8'h00;
			b2_q     <= 8'h00;
			b3_q     <= 8'h00;
			pc_q     <= `LCCE_PC_RST;
			bank_q   <= 2'h0;
		end else if (i_start && o_ready) begin
			opcode_q <= i_opcode;
			b2_q     <= i_byte2;
			b3_q     <= i_byte3;
			pc_q     <= i_pc;
			bank_q   <= i_bank;
		end
	end

	// machine-cycle clock count since the instruction was taken
	always_ff @(posedge i_mclk) begin
		if (i_rst || (i_start && o_ready)) begin
			cnt_q <= '0;
		end else if (state_q != S_IDLE) begin
			cnt_q <= cnt_q + `LCCE_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer; decode is valid from the state after capture
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (i_start) begin
						state_q <= S_PTR;
					end
				end
				S_PTR: begin
					if (dec_src == SRC_IND) begin
						state_q <= S_RD;
					end else if (dec_src == SRC_NONE) begin
						state_q <= S_EXEC;
					end else begin
						state_q <= S_RDW;
					end
				end
				S_RD: state_q <= S_RDW;
				S_RDW: state_q <= S_EXEC;
				S_EXEC: begin
					if (commit) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	// reads: S_PTR fetches the register (or direct/bit byte), S_RD the pointed-to location
	always_comb begin
		o_rd_en    = 1'b0;
		o_rd_addr  = 8'h00;
		o_rd_ind   = 1'b0;
		o_rd_latch = 1'b0;
		if (state_q == S_PTR) begin
			o_rd_en = (dec_src != SRC_NONE);
			unique case (dec_src)
				SRC_REG: o_rd_addr = {3'b000, bank_q, opcode_q[2:0]};
				SRC_IND: o_rd_addr = {3'b000, bank_q, 2'b00, opcode_q[0]};
				SRC_DIR: o_rd_addr = b2_q;
				SRC_BIT: o_rd_addr = bit_byte;
				default: o_rd_addr = 8'h00;
			endcase
			// read-modify-write takes the port latch; a plain compare still sees the pins
			o_rd_latch = dec_dst_dir || (dec_opc == OPC_CLR_BIT) || (dec_opc == OPC_CPL_BIT);
		end else if (state_q == S_RD) begin
			o_rd_en   = 1'b1;
			o_rd_addr = i_rd_data;
			o_rd_ind  = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			opnd_q <= 8'h00;
		end else if (state_q == S_RDW) begin
			opnd_q <= i_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result and commit; all update enables are one-cycle registered pulses, data outputs hold their last value
	logic [7:0]  res_byte;
	logic [7:0]  cmp_a;
	logic [7:0]  cmp_b;
	logic        src_bit;
	logic [15:0] pc_seq;

	always_comb begin
		src_bit  = opnd_q[bit_pos] ^ dec_inv;
		pc_seq   = pc_q + {14'h0000, dec_len};
		cmp_a    = (dec_src == SRC_REG || dec_src == SRC_IND) ? opnd_q : i_acc;
		cmp_b    = (dec_src == SRC_DIR) ? opnd_q : b2_q;
		res_byte = 8'h00;
		if (dec_dst_dir) begin
			res_byte = opnd_q & (dec_use_imm ? b3_q : i_acc);
		end else begin
			res_byte = i_acc & ((dec_use_imm) ? b2_q : opnd_q);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_acc_we   <= 1'b0;
			o_acc_data <= 8'h00;
			o_cy_we    <= 1'b0;
			o_cy_data  <= 1'b0;
			o_pc_we    <= 1'b0;
			o_pc_data  <= `LCCE_PC_RST;
			o_wr_en    <= 1'b0;
			o_wr_addr  <= 8'h00;
			o_wr_data  <= 8'h00;
			o_done     <= 1'b0;
			o_bad_op   <= 1'b0;
		end else begin
			o_acc_we <= 1'b0;
			o_cy_we  <= 1'b0;
			o_pc_we  <= commit;
			o_wr_en  <= 1'b0;
			o_done   <= commit;
			o_bad_op <= commit && (dec_opc == OPC_NONE);
			if (commit) begin
				o_pc_data <= pc_seq;
				unique case (dec_opc)
					OPC_AND_BYTE: begin
						o_acc_we   <= !dec_dst_dir;
						o_acc_data <= res_byte;
						o_wr_en    <= dec_dst_dir;
						o_wr_addr  <= b2_q;
						o_wr_data  <= res_byte;
					end
					OPC_AND_BIT: begin
						o_cy_we   <= 1'b1;
						o_cy_data <= i_cy & src_bit;
					end
					OPC_CMP: begin
						o_cy_we   <= 1'b1;
						o_cy_data <= (cmp_a < cmp_b);
						if (cmp_a != cmp_b) begin
							o_pc_data <= pc_seq + {{8{b3_q[7]}}, b3_q};
						end
					end
					OPC_CLR_A: begin
						o_acc_we   <= 1'b1;
						o_acc_data <= 8'h00;
					end
					OPC_CPL_A: begin
						o_acc_we   <= 1'b1;
						o_acc_data <= ~i_acc;
					end
					OPC_CLR_C: begin
						o_cy_we   <= 1'b1;
						o_cy_data <= 1'b0;
					end
					OPC_CPL_C: begin
						o_cy_we   <= 1'b1;
						o_cy_data <= ~i_cy;
					end
					OPC_CLR_BIT, OPC_CPL_BIT: begin
						o_wr_en   <= 1'b1;
						o_wr_addr <= bit_byte;
						o_wr_data <= opnd_q;
						o_wr_data[bit_pos] <= (dec_opc == OPC_CPL_BIT) ? ~opnd_q[bit_pos] : 1'b0;
					end
					default: o_acc_we <= 1'b0;
				endcase
			end
		end
	end
endmodule : lcce_exec

// File: lcce_exec_chk.sv
// assertions on the ports of lcce_exec
// assumes one core clock and the synchronous active-high reset
`include "lcce_cfg.svh"
module lcce_exec_chk (
	// clock, reset, request
	input wire logic       i_mclk,
	input wire logic       i_rst,
	input wire logic       i_start,
	input wire logic [7:0] i_opcode,
	input wire logic [7:0] i_byte2,
	input wire logic [7:0] i_acc,
	// results
	input wire logic       o_ready,
	input wire logic       o_acc_we,
	input wire logic [7:0] o_acc_data,
	input wire logic       o_cy_we,
	input wire logic       o_cy_data,
	input wire logic       o_pc_we,
	input wire logic       o_wr_en,
	input wire logic       o_done,
	input wire logic       o_bad_op
);
	timeunit 1ns;
	timeprecision 1ns;
	logic take;
	assign take = i_start && o_ready;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	////////////////////////////////
	// a take edge is followed by at least four busy cycles, one machine cycle
	chk_busy_span: assert property (take |=> !o_ready [*4]) else $error("ready back too soon");
	chk_done_bound: assert property (take |-> ##[5:17] o_done) else $error("no done in time");
	chk_done_pc: assert property (o_done |-> o_ready && o_pc_we) else $error("done without pc");
	chk_commit_only: assert property ((o_wr_en || o_acc_we || o_cy_we) |-> o_done) else $error("update off commit");
	chk_bad_quiet: assert property (o_bad_op |-> o_done && !(o_wr_en || o_acc_we || o_cy_we))
		else $error("bad op updated");
	chk_clr_acc: assert property (take && i_opcode == `LCCE_OP_CLR_A
		|-> ##5 o_acc_we && o_acc_data == 8'h00 && !o_cy_we) else $error("acc not cleared");
	chk_cpl_acc: assert property (take && i_opcode == `LCCE_OP_CPL_A
		|-> ##5 o_acc_we && o_acc_data == ~$past(i_acc)) else $error("acc not inverted");
	chk_and_flags: assert property (take && i_opcode[7:3] == `LCCE_OP_AND_A_RN
		|-> ##5 o_acc_we && !o_cy_we) else $error("byte and touched carry");
	chk_cmp_carry: assert property (take && i_opcode == `LCCE_OP_CMP_A_IMM
		|-> ##17 o_cy_we && o_cy_data == ($past(i_acc) < $past(i_byte2, 17))) else $error("compare carry wrong");
endmodule : lcce_exec_chk

bind lcce_exec lcce_exec_chk u_chk (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .i_opcode(i_opcode), .i_byte2(i_byte2),
	.i_acc(i_acc), .o_ready(o_ready), .o_acc_we(o_acc_we), .o_acc_data(o_acc_data), .o_cy_we(o_cy_we),
	.o_cy_data(o_cy_data), .o_pc_we(o_pc_we), .o_wr_en(o_wr_en), .o_done(o_done), .o_bad_op(o_bad_op)
);

// File: lcce_mem_model.sv
// behavioural internal data memory: ram, sfr output latches and pins
// answers a read one clock after the strobe; pins read as the inverse of the latch
module lcce_mem_model (
	// clock
	input  wire logic       i_mclk,
	// read side
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_rd_addr,
	input  wire logic       i_rd_ind,
	input  wire logic       i_rd_latch,
	output logic      [7:0] o_rd_data,
	// write side
	input  wire logic       i_wr_en,
	input  wire logic [7:0] i_wr_addr,
	input  wire logic [7:0] i_wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ram [256];
	logic [7:0] sfr [128];
	logic [7:0] rd_q = 8'h5A;
	assign o_rd_data = rd_q;
	// odd cells hold wide values so some pointers reach the upper ram half
	initial begin
		for (int k = 0; k < 256; k++) begin
			ram[k] = k[0] ? 8'(k * 77) : 8'(k % 4);
			sfr[k % 128] = 8'(~k);
		end
	end
	////////////////////////////////
	// outside a read the data toggles, so a late sample never matches
	always @(posedge i_mclk) begin
		if (!i_rd_en)
			rd_q <= ~rd_q;
		else if (i_rd_ind || !i_rd_addr[7])
			rd_q <= ram[i_rd_addr];
		else
			rd_q <= i_rd_latch ? sfr[i_rd_addr[6:0]] : ~sfr[i_rd_addr[6:0]];
	end
	always @(posedge i_mclk) begin
		if (i_wr_en && i_wr_addr[7])
			sfr[i_wr_addr[6:0]] <= i_wr_data;
		else if (i_wr_en)
			ram[i_wr_addr] <= i_wr_data;
	end
endmodule : lcce_mem_model

// File: testbench.sv
// random instructions of the group checked against a behavioural model
// assumes lcce_mem_model as data memory and the checker bound to the unit
`include "lcce_cfg.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_mclk, i_rst, i_start, i_cy, o_ready, o_rd_en, o_rd_ind, o_rd_latch, o_wr_en;
	logic        o_acc_we, o_cy_we, o_cy_data, o_pc_we, o_done, o_bad_op, ec, ew, cm, bad;
	logic [7:0]  i_opcode, i_byte2, i_byte3, i_acc, i_rd_data, o_rd_addr, o_wr_addr, o_wr_data;
	logic [7:0]  o_acc_data, ea, ewa, ewd;
	logic [15:0] i_pc, o_pc_data, ep, ln;
	logic [1:0]  i_bank;
	int          error_cnt = 0, num_checks = 0, cycles = 0, n;
	logic [7:0]  ops [20] = '{8'h58, 8'h56, 8'h55, 8'h54, 8'h52, 8'h53, 8'h82, 8'hB0, 8'hB5, 8'hB4,
		8'hB8, 8'hB6, 8'hE4, 8'hC3, 8'hC2, 8'hF4, 8'hB3, 8'hB2, 8'h00, 8'hA5};
	lcce_exec i_lcce_exec (.*);
	lcce_mem_model u_mem (.i_mclk(i_mclk), .i_rd_en(o_rd_en), .i_rd_addr(o_rd_addr), .i_rd_ind(o_rd_ind),
		.i_rd_latch(o_rd_latch), .o_rd_data(i_rd_data), .i_wr_en(o_wr_en), .i_wr_addr(o_wr_addr),
		.i_wr_data(o_wr_data));
	////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask : check
	// sfr reads give the latch only on read-modify-write
	function automatic logic [7:0] rd(input logic [7:0] a, input logic l);
		return a[7] ? (l ? u_mem.sfr[a[6:0]] : ~u_mem.sfr[a[6:0]]) : u_mem.ram[a];
	endfunction : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ew = 1'b1;
		ewa = a;
		ewd = d;
	endtask : wr
	task automatic cmp(input logic [7:0] x, input logic [7:0] y);
		cm = 1'b1;
		ec = x < y;
		ep = i_pc + 16'h0003 + ((x != y) ? {{8{i_byte3[7]}}, i_byte3} : 16'h0000);
	endtask : cmp
	task automatic model();
		logic [7:0] rn, ri, ba, bp, bl;
		rn = {3'h0, i_bank, i_opcode[2:0]};
		ri = u_mem.ram[{3'h0, i_bank, 2'h0, i_opcode[0]}];
		ba = i_byte2[7] ? {i_byte2[7:3], 3'h0} : {4'h2, i_byte2[6:3]};
		bp = rd(ba, 1'b0);
		bl = rd(ba, 1'b1);
		ea = i_acc;
		ec = i_cy;
		ew = 1'b0;
		cm = 1'b0;
		bad = 1'b0;
		case (i_opcode)
			`LCCE_OP_AND_A_DIR: ea = i_acc & rd(i_byte2, 1'b0);
			`LCCE_OP_AND_A_IMM: ea = i_acc & i_byte2;
			`LCCE_OP_AND_D_A: wr(i_byte2, rd(i_byte2, 1'b1) & i_acc);
			`LCCE_OP_AND_D_IMM: wr(i_byte2, rd(i_byte2, 1'b1) & i_byte3);
			`LCCE_OP_AND_C_BIT: ec = i_cy & bp[i_byte2[2:0]];
			`LCCE_OP_AND_C_NBIT: ec = i_cy & !bp[i_byte2[2:0]];
			`LCCE_OP_CMP_A_DIR: cmp(i_acc, rd(i_byte2, 1'b0));
			`LCCE_OP_CMP_A_IMM: cmp(i_acc, i_byte2);
			`LCCE_OP_CLR_A: ea = 8'h00;
			`LCCE_OP_CLR_C: ec = 1'b0;
			`LCCE_OP_CLR_BIT: wr(ba, bl & ~(8'h01 << i_byte2[2:0]));
			`LCCE_OP_CPL_A: ea = ~i_acc;
			`LCCE_OP_CPL_C: ec = !i_cy;
			`LCCE_OP_CPL_BIT: wr(ba, bl ^ (8'h01 << i_byte2[2:0]));
			default:
				if (i_opcode[7:3] == `LCCE_OP_AND_A_RN) ea = i_acc & u_mem.ram[rn];
				else if (i_opcode[7:1] == `LCCE_OP_AND_A_IND) ea = i_acc & u_mem.ram[ri];
				else if (i_opcode[7:3] == `LCCE_OP_CMP_RN) cmp(u_mem.ram[rn], i_byte2);
				else if (i_opcode[7:1] == `LCCE_OP_CMP_IND) cmp(u_mem.ram[ri], i_byte2);
				else bad = 1'b1;
		endcase
		ln = 16'h0002;
		if (bad || i_opcode inside {`LCCE_OP_CLR_A, `LCCE_OP_CLR_C, `LCCE_OP_CPL_A, `LCCE_OP_CPL_C}
			|| i_opcode[7:3] == `LCCE_OP_AND_A_RN || i_opcode[7:1] == `LCCE_OP_AND_A_IND)
			ln = 16'h0001;
		if (cm || i_opcode == `LCCE_OP_AND_D_IMM)
			ln = 16'h0003;
		n = cm ? 4 : int'(ln);
		if (!cm)
			ep = i_pc + ln;
	endtask : model
	task automatic run_one(input int t);
		int i, cy, gw;
		logic [63:0] r;
		logic [15:0] gp;
		logic [7:0] op, ga, wa, wd;
		logic gc, gb;
		r = {$urandom, $urandom};
		i = (t < 20) ? t : int'(r[63:56]) % 20;
		op = ops[i];
		if (i % 10 == 0)
			op[2:0] = r[2:0];
		if (i % 10 == 1)
			op[0] = r[0];
		i_opcode = op;
		// narrow operands on odd turns so compares often hit equality
		i_byte2 = t[0] ? {6'h00, r[9:8]} : r[15:8];
		i_acc = t[0] ? {6'h00, r[17:16]} : r[23:16];
		i_byte3 = r[31:24];
		i_pc = r[47:32];
		i_bank = r[49:48];
		i_cy = r[50];
		i_start = 1'b1;
		@(posedge i_mclk);
		#1;
		model();
		ga = i_acc;
		gc = i_cy;
		gp = 16'h0000;
		gb = 1'b0;
		gw = 0;
		cy = 0;
		while (o_done !== 1'b1 && cy < 40) begin
			// requests while busy must be ignored
			r = {$urandom, $urandom};
			i_start = r[0];
			i_opcode = r[15:8];
			i_byte2 = r[23:16];
			i_byte3 = r[31:24];
			i_pc = r[47:32];
			i_bank = r[49:48];
			@(posedge i_mclk);
			#1;
			cy++;
			if (o_acc_we === 1'b1) ga = o_acc_data;
			if (o_cy_we === 1'b1) gc = o_cy_data;
			if (o_pc_we === 1'b1) gp = o_pc_data;
			if (o_bad_op === 1'b1) gb = 1'b1;
			if (o_wr_en === 1'b1) begin
				gw++;
				wa = o_wr_addr;
				wd = o_wr_data;
			end
		end
		check("acc", 16'(ga), 16'(ea));
		check("carry", 16'(gc), 16'(ec));
		check("pc", gp, ep);
		check("writes", 16'(gw), 16'(ew));
		if (ew) begin
			check("wr_addr", 16'(wa), 16'(ewa));
			check("wr_data", 16'(wd), 16'(ewd));
		end
		check("cycles", 16'(cy), 16'(4 * n));
		check("bad_op", 16'(gb), 16'(bad));
	endtask : run_one
	////////////////////////////////
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		{i_start, i_cy, i_opcode, i_byte2, i_byte3, i_acc, i_pc, i_bank} = '0;
		i_rst = 1'b1;
		void'($urandom(35));
		repeat (2) @(posedge i_mclk);
		#1;
		i_rst = 1'b0;
		for (int t = 0; t < 320; t++) begin
			if (t == 160) begin
				i_start = 1'b0;
				i_rst = 1'b1;
				repeat (2) @(posedge i_mclk);
				#1;
				i_rst = 1'b0;
				check("ready", 16'(o_ready), 16'h0001);
				check("done", 16'(o_done), 16'h0000);
			end
			run_one(t);
		end
		i_start = 1'b0;
		final_report();
	end
endmodule : testbench
